// ===== dtpwm_pkg.sv
/*
 Shared constants and types for the dual timer based modulator.
 Assumes a single core clock domain and a plain strobe register port.
*/
package dtpwm_pkg;
  // Register offsets (word index on the plain port)
  localparam logic [3:0] OFF_COUNT = 4'h0;
  localparam logic [3:0] OFF_PERIOD = 4'h1;
  localparam logic [3:0] OFF_TCTRL = 4'h2;
  localparam logic [3:0] OFF_DUTY1 = 4'h3;
  localparam logic [3:0] OFF_BUF1 = 4'h4;
  localparam logic [3:0] OFF_CCTRL1 = 4'h5;
  localparam logic [3:0] OFF_DUTY2 = 4'h6;
  localparam logic [3:0] OFF_BUF2 = 4'h7;
  localparam logic [3:0] OFF_CCTRL2 = 4'h8;
  // Reset values
  localparam logic [7:0] RST_COUNT = 8'h00;
  localparam logic [7:0] RST_PERIOD = 8'hFF;
  localparam logic [7:0] RST_TCTRL = 8'h00;
  localparam logic [7:0] RST_CCTRL = 8'h00;
  localparam logic [7:0] RST_DUTY = 8'h00;
  // Timebase control fields
  localparam int TC_PRE_LO = 0;
  localparam int TC_ON = 2;
  localparam int TC_POST_LO = 3;
  localparam logic [7:0] TC_MASK = 8'h7F;
  // Channel control fields
  localparam int CC_LSB_LO = 4;
  localparam logic [7:0] CC_MASK = 8'h3F;
  // Pwm mode code in the channel control low nibble
  localparam logic [1:0] CC_MODE_PWM = 2'h3;
  localparam int CC_MODE_HI = 3;
  localparam int CC_MODE_LO = 2;
  // Oscillator periods per timer count step at prescale 1
  localparam int PHASES_PER_COUNT = 4;
  // Channel register bundle
  typedef struct packed {
    logic [7:0] dutyHigh;
    logic [1:0] dutyLow;
    logic [1:0] modeSel;
  } dtpwm_chan_cfg_t;
  // Prescale divider from the two select bits: 1, 4, 16
  function automatic logic [4:0] dtpwm_prescale(input logic [1:0] sel);
    case (sel)
      2'h0: dtpwm_prescale = 5'h01;
      2'h1: dtpwm_prescale = 5'h04;
      default: dtpwm_prescale = 5'h10;
    endcase
  endfunction
endpackage

// ===== dtpwm_timebase.sv
/*
 Shared 8-bit timer extended to a 10-bit time base.
 Assumes registers and period come from the top on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
module dtpwm_timebase
  import dtpwm_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic timerOn, // Timer run enable
  input wire logic [1:0] preSel, // Prescale select
  input wire logic [3:0] postSel, // Postscale select
  input wire logic [7:0] period, // Period compare value
  input wire logic countWrite, // Software write of the count
  input wire logic [7:0] countData, // Data of that write
  output logic [7:0] count, // Timer count
  output logic [9:0] extTime, // Count with two fine bits below
  output logic rollover, // Period boundary pulse
  output logic postTick // Slow update-rate event pulse
);
  // Fine counter: 4 oscillator phases times prescale per count step
  logic [5:0] fine;
  logic [3:0] postCnt;
  wire logic [4:0] preDiv = dtpwm_prescale(preSel);
  wire logic [6:0] fineTop = 7'(PHASES_PER_COUNT) * {2'h0, preDiv} - 7'h01;
  wire logic fineWrap = ({1'b0, fine} == fineTop);
  // Two fine bits: the phase clock, or top prescaler bits when prescaling
  wire logic [1:0] fineBits = (preSel == 2'h0) ? fine[1:0] :
                              (preSel == 2'h1) ? fine[3:2] : fine[5:4];
  wire logic atPeriod = (count == period);
  wire logic stepNow = timerOn && fineWrap;
  assign extTime = {count, fineBits};

  // Phase and prescale counter
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      fine <= 6'h00;
    end else if (!timerOn || fineWrap) begin
      fine <= 6'h00;
    end else begin
      fine <= fine + 6'h01;
    end
  end

  // Timer count; clears on the step after a period match
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      count <= RST_COUNT;
      rollover <= 1'b0;
    end else begin
      rollover <= stepNow && atPeriod;
      if (countWrite) begin
        count <= countData;
      end else if (stepNow) begin
        count <= atPeriod ? 8'h00 : count + 8'h01;
      end
    end
  end

  // Postscaler only produces a side event, never touches the period
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      postCnt <= 4'h0;
      postTick <= 1'b0;
    end else begin
      postTick <= 1'b0;
      if (stepNow && atPeriod) begin
        if (postCnt == postSel) begin
          postCnt <= 4'h0;
          postTick <= 1'b1;
        end else begin
          postCnt <= postCnt + 4'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== dtpwm_channel.sv
/*
 One modulator channel: double-buffered duty and 10-bit compare.
 Assumes rollover and extended time come from the shared time base.
*/
`timescale 1ns/1ns
`default_nettype none
module dtpwm_channel
  import dtpwm_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire dtpwm_chan_cfg_t cfg, // Software duty and mode
  input wire logic rollover, // Period boundary
  input wire logic [9:0] extTime, // Extended time base
  output logic [7:0] dutyBuffer, // Read-only buffered high bits
  output logic pinOut // Modulator pin
);
  logic [1:0] dutyLatch; // Hidden low bits of the buffered duty
  wire logic [9:0] nextDuty = {cfg.dutyHigh, cfg.dutyLow};
  wire logic pwmOn = (cfg.modeSel == CC_MODE_PWM);
  // Compare against the buffered copy only, so mid-period writes cannot glitch
  wire logic match = ({dutyBuffer, dutyLatch} == extTime);

  // Buffer reload at each boundary
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dutyBuffer <= RST_DUTY;
      dutyLatch <= 2'h0;
    end else if (rollover) begin
      dutyBuffer <= cfg.dutyHigh;
      dutyLatch <= cfg.dutyLow;
    end
  end

  // Pin set at boundary unless zero duty; cleared on match.
  // A duty past the period never matches, so the pin stays high.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pinOut <= 1'b0;
    end else if (!pwmOn) begin
      pinOut <= 1'b0;
    end else if (rollover) begin
      pinOut <= (nextDuty != 10'h000);
    end else if (match) begin
      pinOut <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== dtpwm_top.sv
/*
 Top of the dual timer based modulator: register port, shared timer,
 two channels. Assumes a one-clock strobe master and a power stage on pins.
*/
`timescale 1ns/1ns
`default_nettype none
module dtpwm_top
  import dtpwm_pkg::*;
#(
  parameter int DUTY_BITS = 10 // Unused; duty resolution is set by the fixed 10-bit compare
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [3:0] regAddr, // Register index
  input wire logic [7:0] regWdata, // Write data
  input wire logic regWrite, // Write strobe
  input wire logic regRead, // Read strobe
  output logic [7:0] regRdata, // Read data, cycle after the strobe
  output logic modulatorOutputA, // Channel 1 pin
  output logic modulatorOutputB, // Channel 2 pin
  output logic updateTick // Slow postscaled event pulse
);
  // Software registers
  logic [7:0] timebasePeriod;
  logic [7:0] timebaseControl;
  logic [7:0] dutyHighBitsCh1;
  logic [7:0] dutyHighBitsCh2;
  logic [7:0] channelControlCh1;
  logic [7:0] channelControlCh2;
  // Time base and channel results
  wire logic [7:0] timebaseCount;
  wire logic [9:0] extTime;
  wire logic rollover;
  wire logic postTick;
  wire logic [7:0] dutyBufferCh1;
  wire logic [7:0] dutyBufferCh2;
  wire logic pinA;
  wire logic pinB;

  // Address decode
  wire logic wrCount = regWrite && (regAddr == OFF_COUNT);
  wire logic wrPeriod = regWrite && (regAddr == OFF_PERIOD);
  wire logic wrTctrl = regWrite && (regAddr == OFF_TCTRL);
  wire logic wrDuty1 = regWrite && (regAddr == OFF_DUTY1);
  wire logic wrCctrl1 = regWrite && (regAddr == OFF_CCTRL1);
  wire logic wrDuty2 = regWrite && (regAddr == OFF_DUTY2);
  wire logic wrCctrl2 = regWrite && (regAddr == OFF_CCTRL2);

  // Channel configuration bundles; low duty bits from control bits 5:4
  wire dtpwm_chan_cfg_t cfg1 = '{dutyHigh: dutyHighBitsCh1,
    dutyLow: channelControlCh1[CC_LSB_LO+1:CC_LSB_LO],
    modeSel: channelControlCh1[CC_MODE_HI:CC_MODE_LO]};
  wire dtpwm_chan_cfg_t cfg2 = '{dutyHigh: dutyHighBitsCh2,
    dutyLow: channelControlCh2[CC_LSB_LO+1:CC_LSB_LO],
    modeSel: channelControlCh2[CC_MODE_HI:CC_MODE_LO]};

  // Read mux; unmapped indices read zero. Reserved bits read zero.
  logic [7:0] readMux;
  always_comb begin
    case (regAddr)
      OFF_COUNT: readMux = timebaseCount;
      OFF_PERIOD: readMux = timebasePeriod;
      OFF_TCTRL: readMux = timebaseControl;
      OFF_DUTY1: readMux = dutyHighBitsCh1;
      OFF_BUF1: readMux = dutyBufferCh1;
      OFF_CCTRL1: readMux = channelControlCh1;
      OFF_DUTY2: readMux = dutyHighBitsCh2;
      OFF_BUF2: readMux = dutyBufferCh2;
      OFF_CCTRL2: readMux = channelControlCh2;
      default: readMux = 8'h00;
    endcase
  end

  // Register writes; buffer registers ignore writes
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      timebasePeriod <= RST_PERIOD;
      timebaseControl <= RST_TCTRL;
      dutyHighBitsCh1 <= RST_DUTY;
      dutyHighBitsCh2 <= RST_DUTY;
      channelControlCh1 <= RST_CCTRL;
      channelControlCh2 <= RST_CCTRL;
    end else begin
      if (wrPeriod) begin
        timebasePeriod <= regWdata;
      end
      if (wrTctrl) begin
        timebaseControl <= regWdata & TC_MASK;
      end
      if (wrDuty1) begin
        dutyHighBitsCh1 <= regWdata;
      end
      if (wrCctrl1) begin
        channelControlCh1 <= regWdata & CC_MASK;
      end
      if (wrDuty2) begin
        dutyHighBitsCh2 <= regWdata;
      end
      if (wrCctrl2) begin
        channelControlCh2 <= regWdata & CC_MASK;
      end
    end
  end

  // Read data and pins straight from flip-flops
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      regRdata <= 8'h00;
      modulatorOutputA <= 1'b0;
      modulatorOutputB <= 1'b0;
      updateTick <= 1'b0;
    end else begin
      regRdata <= regRead ? readMux : 8'h00;
      modulatorOutputA <= pinA;
      modulatorOutputB <= pinB;
      updateTick <= postTick;
    end
  end

  // Shared time base for both channels
  dtpwm_timebase u_timebase (
    .core_clk(core_clk),
    .rst(rst),
    .timerOn(timebaseControl[TC_ON]),
    .preSel(timebaseControl[TC_PRE_LO+1:TC_PRE_LO]),
    .postSel(timebaseControl[TC_POST_LO+3:TC_POST_LO]),
    .period(timebasePeriod),
    .countWrite(wrCount),
    .countData(regWdata),
    .count(timebaseCount),
    .extTime(extTime),
    .rollover(rollover),
    .postTick(postTick)
  );

  // Two identical channels on the same time base
  dtpwm_channel u_ch1 (
    .core_clk(core_clk),
    .rst(rst),
    .cfg(cfg1),
    .rollover(rollover),
    .extTime(extTime),
    .dutyBuffer(dutyBufferCh1),
    .pinOut(pinA)
  );

  dtpwm_channel u_ch2 (
    .core_clk(core_clk),
    .rst(rst),
    .cfg(cfg2),
    .rollover(rollover),
    .extTime(extTime),
    .dutyBuffer(dutyBufferCh2),
    .pinOut(pinB)
  );
  // Resolution follows from the 10-bit compare and the period length
endmodule
`default_nettype wire

// ===== dtpwm_props.sv
/*
 Checker for the modulator register port and update tick.
 Assumes it sees only the top ports, all on core_clk.
*/
`timescale 1ns/1ns
`default_nettype none
module dtpwm_props
  import dtpwm_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regRdata,
  input wire logic modulatorOutputA,
  input wire logic modulatorOutputB,
  input wire logic updateTick
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // Read data is zero outside its answer cycle
  property p_rdIdle; !$past(regRead) |-> regRdata == 8'h00; endproperty
  a_rdIdle: assert property (p_rdIdle) else $error("read data not idle");
  property p_unmapped; regRead && regAddr > OFF_CCTRL2 |=> regRdata == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_tcRsv; regRead && regAddr == OFF_TCTRL |=> !regRdata[7]; endproperty
  a_tcRsv: assert property (p_tcRsv) else $error("reserved timer bit set");
  // Write then read of the same place returns what was written, with masked reserved bits reading zero
  property p_period;
    regWrite && regAddr == OFF_PERIOD ##1 regRead && regAddr == OFF_PERIOD
      |=> regRdata == $past(regWdata, 2);
  endproperty
  a_period: assert property (p_period) else $error("period readback");
  property p_duty;
    regWrite && regAddr == OFF_DUTY1 ##1 regRead && regAddr == OFF_DUTY1
      |=> regRdata == $past(regWdata, 2);
  endproperty
  a_duty: assert property (p_duty) else $error("duty readback");
  property p_cctrl;
    regWrite && regAddr == OFF_CCTRL1 ##1 regRead && regAddr == OFF_CCTRL1
      |=> regRdata == ($past(regWdata, 2) & CC_MASK);
  endproperty
  a_cctrl: assert property (p_cctrl) else $error("channel control readback");
  property p_tctrl;
    regWrite && regAddr == OFF_TCTRL ##1 regRead && regAddr == OFF_TCTRL
      |=> regRdata == ($past(regWdata, 2) & TC_MASK);
  endproperty
  a_tctrl: assert property (p_tctrl) else $error("timer control readback");
  // Slow event is a single-cycle pulse
  property p_tick; $rose(updateTick) |=> !updateTick; endproperty
  a_tick: assert property (p_tick) else $error("tick longer than a cycle");
  c_wrRd: cover property (regWrite ##1 regRead);
  c_riseA: cover property ($rose(modulatorOutputA));
  c_tick: cover property ($rose(updateTick));
endmodule
bind dtpwm_top dtpwm_props chk (.core_clk(core_clk), .rst(rst), .regAddr(regAddr),
  .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
  .modulatorOutputA(modulatorOutputA), .modulatorOutputB(modulatorOutputB),
  .updateTick(updateTick));
`default_nettype wire

// ===== dtpwm_power_leg.sv
/*
 One power stage leg: measures gate high time and period.
 Assumes the gate is a registered level on core_clk.
*/
`timescale 1ns/1ns
`default_nettype none
module dtpwm_power_leg (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic gate,
  output logic [15:0] highLen,
  output logic [15:0] periodLen,
  output logic [15:0] rises
);
  logic [15:0] hiCnt; // High cycles this period
  logic [15:0] perCnt; // Cycles since last rise
  logic gateQ; // Gate one cycle ago
  // A rise closes the previous period and latches its figures
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      {highLen, periodLen, rises, hiCnt, perCnt, gateQ} <= '0;
    end else begin
      gateQ <= gate;
      if (gate && !gateQ) begin
        periodLen <= perCnt;
        highLen <= hiCnt;
        rises <= rises + 16'h0001;
        perCnt <= 16'h0001;
        hiCnt <= 16'h0001;
      end else begin
        perCnt <= perCnt + 16'h0001;
        hiCnt <= hiCnt + {15'h0000, gate};
      end
    end
  end
endmodule
`default_nettype wire

// ===== tb_dual_timer_based_pwm.sv
/*
 Self-checking bench for the dual modulator.
 Assumes a one-cycle strobe register port and the leg models on the pins.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_dual_timer_based_pwm;
  import dtpwm_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWdata = 8'h00;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [7:0] regRdata;
  logic outA, outB, updateTick;
  logic [15:0] hiA, perA, risesA, risesB;
  int num_errors = 0;
  int cmp_count = 0;
  int tickCnt = 0; // Slow event pulses seen so far
  always #50 core_clk = ~core_clk;
  // Counts slow event pulses so the postscale rate can be judged
  always @(posedge core_clk) begin
    if (updateTick === 1'b1) begin
      tickCnt <= tickCnt + 1;
    end
  end
  dtpwm_top dut (.core_clk(core_clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .modulatorOutputA(outA),
    .modulatorOutputB(outB), .updateTick(updateTick));
  dtpwm_power_leg legA (.core_clk(core_clk), .rst(rst), .gate(outA), .highLen(hiA),
    .periodLen(perA), .rises(risesA));
  dtpwm_power_leg legB (.core_clk(core_clk), .rst(rst), .gate(outB), .highLen(),
    .periodLen(), .rises(risesB));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Write strobe stays up across back-to-back writes
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    regRead <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic idle;
    regWrite <= 1'b0;
    @(posedge core_clk);
  endtask
  // Data is looked at only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string what);
    regAddr <= a;
    regRead <= 1'b1;
    regWrite <= 1'b0;
    @(posedge core_clk);
    regRead <= 1'b0;
    #1 check(what, {8'h00, regRdata}, {8'h00, exp});
    @(posedge core_clk);
  endtask
  task automatic waitRises(input int n);
    logic [15:0] start;
    int k;
    start = risesA;
    for (k = 0; k < 5000 && risesA < start + n; k++) @(posedge core_clk);
    // A wait that runs out is counted as a mismatch
    check("rise wait", risesA - start, n[15:0]);
  endtask
  task automatic t_regs;
    rd(OFF_COUNT, RST_COUNT, "count");
    rd(OFF_PERIOD, RST_PERIOD, "period");
    rd(OFF_TCTRL, RST_TCTRL, "tctrl");
    rd(OFF_CCTRL2, RST_CCTRL, "cctrl2");
    rd(4'hF, 8'h00, "unmapped");
    wr(OFF_BUF1, 8'hAA);
    rd(OFF_BUF1, RST_DUTY, "buffer write");
    wr(OFF_COUNT, 8'h05);
    rd(OFF_COUNT, 8'h05, "count write");
    wr(OFF_CCTRL1, 8'hFF);
    rd(OFF_CCTRL1, 8'h3F, "cctrl reserved");
    wr(OFF_DUTY1, 8'h03);
    rd(OFF_DUTY1, 8'h03, "duty");
    wr(OFF_TCTRL, 8'hFF);
    rd(OFF_TCTRL, 8'h7F, "tctrl reserved");
    wr(OFF_TCTRL, 8'h00);
    idle;
    $display("test regs done");
  endtask
  // Every prescale code, postscale varied alongside; duty 13 on A, zero on B
  task automatic t_run;
    int s;
    int ticks;
    logic [15:0] pre;
    wr(OFF_PERIOD, 8'h09);
    rd(OFF_PERIOD, 8'h09, "period write");
    wr(OFF_COUNT, 8'h00);
    wr(OFF_CCTRL1, 8'h1C);
    wr(OFF_DUTY2, 8'h00);
    wr(OFF_CCTRL2, 8'h0C);
    for (s = 0; s < 4; s++) begin
      pre = (s == 0) ? 16'h0001 : (s == 1) ? 16'h0004 : 16'h0010;
      wr(OFF_TCTRL, {1'b0, 2'b00, s[1:0], 1'b1, s[1:0]});
      idle;
      waitRises(3);
      check("period len", perA, 16'd40 * pre);
      check("high len", hiA, 16'd13 * pre);
      // One slow event in every postscale+1 boundaries, period untouched
      ticks = tickCnt;
      waitRises(s + 1);
      check("ticks per window", 16'(tickCnt - ticks), 16'h0001);
    end
    check("zero duty rises", risesB, 16'h0000);
    $display("test run done");
  endtask
  // New duty waits for the boundary, then governs the next period
  task automatic t_buffer;
    waitRises(1);
    wr(OFF_DUTY1, 8'h05);
    rd(OFF_BUF1, 8'h03, "buffer held");
    waitRises(1);
    rd(OFF_BUF1, 8'h05, "buffer loaded");
    waitRises(1);
    check("new high len", hiA, 16'd336);
    $display("test buffer done");
  endtask
  task automatic t_edges;
    int k;
    int lows;
    logic [15:0] rb;
    wr(OFF_DUTY2, 8'hFF);
    wr(OFF_CCTRL2, 8'h3C);
    idle;
    waitRises(2);
    lows = 0;
    for (k = 0; k < 700; k++) begin
      @(posedge core_clk);
      if (outB !== 1'b1) lows++;
    end
    check("long duty lows", lows[15:0], 16'h0000);
    // Leaving the modulator mode forces the pin low even with duty set
    wr(OFF_CCTRL2, 8'h30);
    idle;
    idle;
    idle;
    check("mode off pin", {15'h0000, outB}, 16'h0000);
    rb = risesB;
    waitRises(1);
    check("mode off rises", risesB, rb);
    $display("test edges done");
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    t_regs;
    t_run;
    t_buffer;
    t_edges;
    test_done;
  end
  // Tests take under 16000 cycles
  initial begin
    #(30000 * 100);
    num_errors++;
    test_done;
  end
endmodule
`default_nettype wire
